// ### src/uic_pkg.sv
// Package with constants and carrier types for the interface control block
package uic_pkg;

  // APB address width and register indices (byte address is four times the index)
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  IDX_WRITE     = 8'h07;
  localparam logic [7:0]  IDX_SET       = 8'h08;
  localparam logic [7:0]  IDX_CLEAR     = 8'h09;
  localparam logic [7:0]  IDX_STATUS    = 8'h10;
  localparam logic [7:0]  ADDR_WRITE    = 8'(IDX_WRITE * 8'h04);
  localparam logic [7:0]  ADDR_SET      = 8'(IDX_SET * 8'h04);
  localparam logic [7:0]  ADDR_CLEAR    = 8'(IDX_CLEAR * 8'h04);
  localparam logic [7:0]  ADDR_STATUS   = 8'(IDX_STATUS * 8'h04);

  // Interface control field positions and reset value
  localparam int unsigned BIT_SIX_WIRE  = 0;
  localparam int unsigned BIT_THREE_WIRE = 1;
  localparam int unsigned BIT_CLK_POWER = 3;
  localparam int unsigned BIT_INVERT    = 5;
  localparam int unsigned BIT_BYPASS    = 6;
  localparam int unsigned BIT_PROT_DIS  = 7;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_MASK     = 8'hEB;

  // Status field positions
  localparam int unsigned ST_RELEASED   = 0;
  localparam int unsigned ST_LOW_POWER  = 1;
  localparam int unsigned ST_STOP       = 2;
  localparam int unsigned ST_COMPL      = 3;
  localparam int unsigned ST_BUS_VALID  = 4;
  localparam int unsigned ST_CLK_ON     = 5;

  // Stop line must stay high this long (ns) before it counts as released
  localparam int unsigned STOP_HOLD_NS  = 40;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned STOP_HOLD_CYC =
    (STOP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W        = 4;

  // Protection detector states
  typedef enum logic [2:0] {
    PROT_IDLE     = 3'b001,
    PROT_HIGH     = 3'b010,
    PROT_RELEASED = 3'b100
  } uic_prot_state_t;

  // Pad control towards the ULPI pins
  typedef struct packed {
    logic stp_pullup_en;
    logic data_pulldown_en;
  } uic_pad_ctrl_t;

  // Alternative interface selection
  typedef struct packed {
    logic three_wire_serial_mode;
    logic six_wire_serial_mode;
  } uic_mode_t;

endpackage

// ### src/uic_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module uic_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,    // Clock
  input  wire logic             presetn, // Async reset, active low
  input  wire logic [WIDTH-1:0] d_in,    // Asynchronous input
  output logic      [WIDTH-1:0] q_out    // Synchronised output
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;

endmodule

// ### src/uic_interface_control.sv
// Interface control register with APB access, pin protection and indicator logic
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module uic_interface_control
  import uic_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = STOP_HOLD_CYC
) (
  input  wire logic              pclk,             // Interface clock
  input  wire logic              presetn,          // Async reset, active low
  input  wire logic              psel,             // APB select
  input  wire logic              penable,          // APB enable
  input  wire logic              pwrite,           // APB direction
  input  wire logic [ADDR_W-1:0] paddr,            // APB byte address
  input  wire logic [31:0]       pwdata,           // APB write data
  output logic      [31:0]       prdata,           // APB read data
  output logic                   pready,           // APB ready
  output logic                   pslverr,          // APB error
  input  wire logic              stop_pin,         // Stop line level from pad
  input  wire logic              fault_pin,        // External fault indicator pin
  input  wire logic              a_device_bus_valid_compare, // Analog comparator
  input  wire logic              phy_low_power_n,  // Suspend control bit
  input  wire logic              three_wire_exit,  // Pulse: three-wire mode left
  input  wire logic              six_wire_exit,    // Pulse: six-wire mode left
  output uic_pad_ctrl_t          pad_ctrl,         // Pull resistor enables
  output uic_mode_t              serial_mode,      // Interface selection
  output logic                   serial_clock_on,  // Clock circuitry powered
  output logic                   bus_valid_report, // Bus state for receive cmds
  output logic                   stop_released,    // Link stopped driving stop
  output logic                   low_power_exit    // Pulse: request low-power exit
);

  logic [7:0]       ctrl_reg;
  logic [7:0]       ctrl_next;
  logic [2:0]       sync_q;
  logic             stop_s;
  logic             fault_s;
  logic             valid_s;
  logic             prot_on;
  logic             compl_v;
  logic             in_serial;
  uic_prot_state_t  prot_reg;
  uic_prot_state_t  prot_next;
  logic [HOLD_W-1:0] hold_reg;
  logic [HOLD_W-1:0] hold_next;
  logic             setup_ph;
  logic             wr_hit;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  uic_pad_ctrl_t    pad_reg;
  uic_mode_t        mode_reg;
  logic             clk_on_reg;
  logic             report_reg;
  logic             released_reg;
  logic             exit_reg;
  logic             stop_prev_reg;

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);

  // Decode whether an address belongs to the control register
  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    return (a == ADDR_WRITE) || (a == ADDR_SET) || (a == ADDR_CLEAR);
  endfunction

  // Pins and the analog comparator are asynchronous to pclk
  uic_sync #(
    .WIDTH (3)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({a_device_bus_valid_compare, fault_pin, stop_pin}),
    .q_out   (sync_q)
  );

  assign stop_s  = sync_q[0];
  assign fault_s = sync_q[1];
  assign valid_s = sync_q[2];

  // Bus phases: answer is prepared in setup so access completes at once
  assign setup_ph = psel && !penable;
  assign wr_hit   = psel && penable && pready_reg && pwrite;

  // Next register value: hardware clears first, a software write then wins
  always_comb begin
    ctrl_next = ctrl_reg;
    if (three_wire_exit) begin
      ctrl_next[BIT_THREE_WIRE] = 1'b0;
    end
    if (six_wire_exit) begin
      ctrl_next[BIT_SIX_WIRE] = 1'b0;
    end
    if (wr_hit) begin
      unique case (paddr)
        ADDR_WRITE: ctrl_next = pwdata[7:0] & CTRL_MASK;
        ADDR_SET:   ctrl_next = ctrl_next | (pwdata[7:0] & CTRL_MASK);
        ADDR_CLEAR: ctrl_next = ctrl_next & ~pwdata[7:0];
        default:    ctrl_next = ctrl_next;
      endcase
    end
  end

  // Control register; reserved bits never store, so they read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // APB answer: zero wait states, error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= 1'b0;
      if (setup_ph) begin
        prdata_reg <= 32'h0000_0000;
        if (is_ctrl(paddr)) begin
          prdata_reg <= {24'h00_0000, ctrl_next};
        end else if (paddr == ADDR_STATUS) begin
          prdata_reg <= {26'h000_0000, clk_on_reg, report_reg, compl_v,
                         stop_s, ~phy_low_power_n, released_reg};
          pslverr_reg <= pwrite;
        end else begin
          pslverr_reg <= 1'b1;
        end
      end
    end
  end

  // Mode selection straight from the control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= '0;
    end else begin
      mode_reg.three_wire_serial_mode <= ctrl_next[BIT_THREE_WIRE];
      mode_reg.six_wire_serial_mode   <= ctrl_next[BIT_SIX_WIRE];
    end
  end

  // Both serial bits together is undefined; the link must avoid it, we just pass it on
  assign in_serial = ctrl_reg[BIT_THREE_WIRE] | ctrl_reg[BIT_SIX_WIRE];

  // Clock power: bit counts only in serial mode while powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_on_reg <= 1'b1;
    end else if (!phy_low_power_n) begin
      clk_on_reg <= 1'b0;
    end else if (in_serial) begin
      clk_on_reg <= ctrl_reg[BIT_CLK_POWER];
    end else begin
      clk_on_reg <= 1'b1;
    end
  end

  // Fault indicator: optional inversion, optional qualification
  assign compl_v = fault_s ^ ctrl_reg[BIT_INVERT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_reg <= 1'b0;
    end else if (ctrl_reg[BIT_BYPASS]) begin
      report_reg <= compl_v;
    end else begin
      report_reg <= compl_v & valid_s;
    end
  end

  // Release detector: a short stop pulse is normal, a long one means floating
  assign prot_on = !ctrl_reg[BIT_PROT_DIS];

  always_comb begin
    prot_next = prot_reg;
    hold_next = hold_reg;
    unique case (prot_reg)
      PROT_IDLE: begin
        hold_next = '0;
        if (prot_on && stop_s) begin
          prot_next = PROT_HIGH;
        end
      end
      PROT_HIGH: begin
        if (!prot_on || !stop_s) begin
          prot_next = PROT_IDLE;
        end else if (hold_reg == HOLD_LAST) begin
          prot_next = PROT_RELEASED;
        end else begin
          hold_next = hold_reg + HOLD_W'(1);
        end
      end
      PROT_RELEASED: begin
        if (!prot_on || !stop_s) begin
          prot_next = PROT_IDLE;
        end
      end
      default: begin
        prot_next = PROT_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_reg <= PROT_IDLE;
      hold_reg <= '0;
    end else begin
      prot_reg <= prot_next;
      hold_reg <= hold_next;
    end
  end

  // Pull resistors follow the protect-disable bit and the detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_reg      <= '{stp_pullup_en: 1'b1, data_pulldown_en: 1'b0};
      released_reg <= 1'b0;
    end else begin
      pad_reg.stp_pullup_en    <= prot_on;
      pad_reg.data_pulldown_en <= prot_on && (prot_next == PROT_RELEASED);
      released_reg             <= prot_next == PROT_RELEASED;
    end
  end

  // Low-power exit: rising stop while suspended asks the owner to clear the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_prev_reg <= 1'b0;
      exit_reg      <= 1'b0;
    end else begin
      stop_prev_reg <= stop_s;
      exit_reg      <= !phy_low_power_n && stop_s && !stop_prev_reg;
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign pad_ctrl         = pad_reg;
  assign serial_mode      = mode_reg;
  assign serial_clock_on  = clk_on_reg;
  assign bus_valid_report = report_reg;
  assign stop_released    = released_reg;
  assign low_power_exit   = exit_reg;

  // Checker helper: consecutive cycles of a protected high stop line, saturating
  localparam logic [HOLD_W:0] HIGH_SAT = (HOLD_W + 1)'(HOLD_CYCLES + 1);
  logic [HOLD_W:0] high_cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt_reg <= '0;
    end else if (!(prot_on && stop_s)) begin
      high_cnt_reg <= '0;
    end else if (high_cnt_reg != HIGH_SAT) begin
      high_cnt_reg <= high_cnt_reg + (HOLD_W + 1)'(1);
    end
  end

  // Assertions next to the logic they guard
  a_write_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit && paddr == ADDR_WRITE |=> ctrl_reg == ($past(pwdata[7:0]) & CTRL_MASK))
    else $error("write address did not store data");

  a_set_bits: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit && paddr == ADDR_SET |=> (ctrl_reg & ($past(pwdata[7:0]) & CTRL_MASK))
      == ($past(pwdata[7:0]) & CTRL_MASK))
    else $error("set address did not set bits");

  a_clear_bits: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit && paddr == ADDR_CLEAR |=> (ctrl_reg & $past(pwdata[7:0])) == 8'h00)
    else $error("clear address did not clear bits");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg & ~CTRL_MASK) == 8'h00)
    else $error("reserved bit stored");

  a_pullup_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[BIT_PROT_DIS] |=> !pad_ctrl.stp_pullup_en && !pad_ctrl.data_pulldown_en)
    else $error("pull resistors left on while disabled");

  a_release_time: assert property (@(posedge pclk) disable iff (!presetn)
    stop_released == (high_cnt_reg == HIGH_SAT))
    else $error("stop release not flagged exactly after the hold time");

  a_pulldown_match: assert property (@(posedge pclk) disable iff (!presetn)
    pad_ctrl.data_pulldown_en == stop_released)
    else $error("data pull-downs disagree with release state");

  a_short_stop: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stop_s) ##1 !stop_s |=> !pad_ctrl.data_pulldown_en)
    else $error("pull-downs on for a short stop pulse");

  a_report_qual: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[BIT_BYPASS] && !valid_s |=> !bus_valid_report)
    else $error("report not qualified by comparator");

  a_invert_pass: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[BIT_BYPASS] |=> bus_valid_report == ($past(fault_s) ^ $past(ctrl_reg[BIT_INVERT])))
    else $error("fault inversion wrong");

  a_clock_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    phy_low_power_n && !in_serial |=> serial_clock_on)
    else $error("clock bit acted outside serial mode");

  a_clock_serial: assert property (@(posedge pclk) disable iff (!presetn)
    phy_low_power_n && in_serial |=> serial_clock_on == $past(ctrl_reg[BIT_CLK_POWER]))
    else $error("clock power does not follow the clock bit");

  a_clock_lowpow: assert property (@(posedge pclk) disable iff (!presetn)
    !phy_low_power_n |=> !serial_clock_on)
    else $error("clock left powered in low power");

  a_mode_follow: assert property (@(posedge pclk) disable iff (!presetn)
    serial_mode == {ctrl_reg[BIT_THREE_WIRE], ctrl_reg[BIT_SIX_WIRE]})
    else $error("serial mode outputs disagree with the register");

  a_mode_clear: assert property (@(posedge pclk) disable iff (!presetn)
    three_wire_exit && !wr_hit |=> !ctrl_reg[BIT_THREE_WIRE])
    else $error("three-wire bit not cleared on exit");

  a_six_clear: assert property (@(posedge pclk) disable iff (!presetn)
    six_wire_exit && !wr_hit |=> !ctrl_reg[BIT_SIX_WIRE] && !serial_mode.six_wire_serial_mode)
    else $error("six-wire bit not cleared on exit");

  a_lp_exit: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_exit |=> !low_power_exit)
    else $error("low-power exit not a single pulse");

endmodule

// ### sim/uic_link_model.sv
// Behavioural model of the link side of the stop line
`timescale 1ns/1ps
module uic_link_model (
  input  wire logic pclk,      // Interface clock
  input  wire logic drive_en,  // Link drives the stop line
  input  wire logic drive_val, // Level the link drives
  input  wire logic pullup_en, // Weak pull-up from the device pad
  output logic      stop_line  // Resolved stop line level
);
  logic last_level;

  // Remember the line so a floating line can be shown as changing
  always_ff @(posedge pclk) begin
    last_level <= stop_line;
  end

  // A released line with no pull-up must not look stable to the device
  assign stop_line = drive_en ? drive_val :
                     (pullup_en ? 1'b1 : ~last_level);
endmodule

// ### sim/tb_top.sv
// Self-checking testbench for the interface control register block
`timescale 1ns/1ps
module tb_top;
  import uic_pkg::*;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic          fault_pin = 0, bus_valid = 0, lp_n = 1, ex3 = 0, ex6 = 0;
  logic          drv_en = 1, drv_val = 0, stop_pin, pready, pslverr, err;
  logic          clk_on, bvr, rel, lpx;
  logic [7:0]    paddr = 8'h00, shadow, d, m;
  logic [31:0]   pwdata = 32'h0000_0000, prdata, rd;
  uic_pad_ctrl_t pad_ctrl;
  uic_mode_t     serial_mode;
  int            n_mismatch = 0, total_checks = 0, n;
  logic [7:0]    addrs [3] = '{ADDR_WRITE, ADDR_SET, ADDR_CLEAR};

  // Clock of 4 ns period
  always #2 pclk = ~pclk;

  // Short hold count keeps the release detection quick
  uic_interface_control #(.HOLD_CYCLES(2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_pin(stop_pin),
    .fault_pin(fault_pin), .a_device_bus_valid_compare(bus_valid),
    .phy_low_power_n(lp_n), .three_wire_exit(ex3), .six_wire_exit(ex6),
    .pad_ctrl(pad_ctrl), .serial_mode(serial_mode), .serial_clock_on(clk_on),
    .bus_valid_report(bvr), .stop_released(rel), .low_power_exit(lpx));

  uic_link_model link (
    .pclk(pclk), .drive_en(drv_en), .drive_val(drv_val),
    .pullup_en(pad_ctrl.stp_pullup_en), .stop_line(stop_pin));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready with no bound of its own
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1) @(posedge pclk);
    chk("pready", pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("register", rd, {24'h000000, exp});
    chk("slverr", err, 1'b0);
  endtask

  // Expected bus state from {valid, fault, bypass, invert}
  function automatic logic exp_bvr(input logic [3:0] k);
    logic c;
    c = k[2] ^ k[0];
    return k[1] ? c : (c & k[3]);
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    void'($urandom(5762));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (addrs[i]) rdchk(addrs[i], 8'h00);
    chk("pads", pad_ctrl, 2'b10);
    shadow = 8'h00;
    // Random write, set and clear; reserved bits never stick
    for (int i = 0; i < 30; i++) begin
      d = (i == 0) ? 8'hFE : 8'($urandom);
      case (i % 3)
        0: begin
          if (d[1] & d[0]) d[0] = 1'b0;
          apb(1'b1, ADDR_WRITE, {24'h000000, d});
          shadow = d & CTRL_MASK;
        end
        1: begin
          d = d & 8'hFC;
          apb(1'b1, ADDR_SET, {24'h000000, d});
          shadow = shadow | (d & CTRL_MASK);
        end
        default: begin
          apb(1'b1, ADDR_CLEAR, {24'h000000, d});
          shadow = shadow & ~d;
        end
      endcase
      rdchk(addrs[$urandom % 3], shadow);
      chk("mode", serial_mode, {shadow[1], shadow[0]});
      chk("pads", pad_ctrl, {~shadow[7], 1'b0});
    end
    apb(1'b0, 8'h80, 32'h0000_0000);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, 32'h0000_0000);
    // Every indicator combination
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, ADDR_WRITE, {25'h0, k[1], k[0], 5'h00});
      fault_pin <= k[2]; bus_valid <= k[3];
      tick(6);
      chk("bus state", bvr, exp_bvr(4'(k)));
    end
    // Clock power across modes, clock bit and low power
    for (int k = 0; k < 16; k++) begin
      m = (k[1:0] == 2'd1) ? 8'h02 : (k[1:0] == 2'd2) ? 8'h01 : 8'h00;
      apb(1'b1, ADDR_WRITE, {24'h000000, m | {4'h0, k[2], 3'h0}});
      lp_n <= k[3];
      tick(4);
      chk("clock", clk_on, !k[3] ? 1'b0 : (m != 8'h00) ? k[2] : 1'b1);
    end
    lp_n <= 1'b1;
    // Mode exit clears its own bit
    apb(1'b1, ADDR_WRITE, 32'h0000_0002);
    ex3 <= 1'b1;
    @(posedge pclk) ex3 <= 1'b0;
    rdchk(ADDR_WRITE, 8'h00);
    apb(1'b1, ADDR_WRITE, 32'h0000_0001);
    ex6 <= 1'b1;
    @(posedge pclk) ex6 <= 1'b0;
    rdchk(ADDR_SET, 8'h00);
    // A one-cycle stop pulse is normal traffic, not a release
    drv_val <= 1'b1;
    @(posedge pclk) drv_val <= 1'b0;
    tick(4);
    chk("released", rel, 1'b0);
    chk("pads", pad_ctrl, 2'b10);
    // Link releases the stop line; the pull-up lifts it
    drv_en <= 1'b0;
    for (n = 0; n < 20 && rel !== 1'b1; n++) @(posedge pclk);
    chk("released", rel, 1'b1);
    chk("pads", pad_ctrl, 2'b11);
    apb(1'b1, ADDR_SET, 32'h0000_0080);
    tick(4);
    chk("pads", pad_ctrl, 2'b00);
    chk("released", rel, 1'b0);
    // Low power left by the link raising stop
    apb(1'b1, ADDR_CLEAR, 32'h0000_0080);
    drv_en <= 1'b1; drv_val <= 1'b0; lp_n <= 1'b0;
    tick(4);
    drv_val <= 1'b1;
    for (n = 0; n < 10 && lpx !== 1'b1; n++) @(posedge pclk);
    chk("exit pulse", lpx, 1'b1);
    @(posedge pclk);
    chk("exit pulse end", lpx, 1'b0);
    lp_n <= 1'b1;
    tick(2);
    wrap_up();
  end
endmodule
